// *** hdl/tbfc_top.v ***
// Transmit bit framing control: APB register bank and antenna driver control.
// Assumes an APB master on clk_i, coder data on the same clock, rx bit index
// from the receiver on the same clock.
`include "tbfc_map.vh"
`timescale 1ns/1ns
`default_nettype none
module tbfc_top (
	input  wire                   clk_i,
	input  wire                   srst_i,
	input  wire                   psel_i,
	input  wire                   penable_i,
	input  wire                   pwrite_i,
	input  wire [`TBFC_ADDR_W-1:0] paddr_i,
	input  wire [31:0]            pwdata_i,
	input  wire [3:0]             pstrb_i,
	output reg  [31:0]            prdata_o,
	output reg                    pready_o,
	output reg                    pslverr_o,
	input  wire                   coder_data_i,
	input  wire                   tx_byte_valid_i,
	input  wire                   tx_byte_last_i,
	input  wire                   tx_done_i,
	input  wire [3:0]             rx_bit_index_i,
	output reg  [2:0]             rx_bit_pos_o,
	output reg                    rx_byte_adv_o,
	output reg  [7:0]             tx_bit_mask_o,
	output reg  [3:0]             tx_bit_count_o,
	output reg                    antenna_drive_a_o,
	output reg                    antenna_drive_b_o,
	output reg  [5:0]             drive_conductance_o,
	output reg                    full_depth_o
);
	reg  [7:0] frame_ff;
	reg  [7:0] pinctl_ff;
	reg  [7:0] cwcond_ff;
	reg  [7:0] modcond_ff;
	reg  [7:0] nxt_frame;
	reg  [7:0] rd_byte;
	reg        mod_in;
	reg        mod_in_ff;
	reg        tx_active_ff;
	wire       carrier;
	wire [7:0] gate_mask;
	wire [3:0] gate_count;
	wire [7:0] reg_idx;
	wire       wr_acc;
	wire       rd_acc;
	wire [3:0] align_sum;

	// Register index decode, byte address is four times the index
	assign reg_idx = paddr_i[`TBFC_ADDR_W-1:`TBFC_IDX_LO];
	assign wr_acc  = psel_i & penable_i & pwrite_i;
	assign rd_acc  = psel_i & penable_i & ~pwrite_i;

	// Mapped-index check
	function is_mapped;
		input [7:0] idx;
		begin
			is_mapped = (idx == `TBFC_IDX_FRAME) || (idx == `TBFC_IDX_PINCTL) ||
				(idx == `TBFC_IDX_CWCOND) || (idx == `TBFC_IDX_MODCOND) ||
				(idx == `TBFC_IDX_BITCOUNT) || (idx == `TBFC_IDX_STATUS);
		end
	endfunction

	// Write hits a register at this index with low lane enabled
	function wr_hit;
		input [7:0] idx;
		input [7:0] want;
		input       acc;
		input       lane;
		begin
			wr_hit = acc & lane & (idx == want);
		end
	endfunction

	// Frame adjust next value; completion clear wins over a software write
	always @* begin
		nxt_frame = frame_ff;
		if (wr_hit(reg_idx, `TBFC_IDX_FRAME, wr_acc, pstrb_i[0]))
			nxt_frame = pwdata_i[7:0] & `TBFC_FRAME_MASK;
		if (tx_done_i)
			nxt_frame[`TBFC_LAST_HI:`TBFC_LAST_LO] = 3'h0;
	end

	// Register storage
	always @(posedge clk_i) begin
		if (srst_i) begin
			frame_ff   <= `TBFC_RST_FRAME;
			pinctl_ff  <= `TBFC_RST_PINCTL;
			cwcond_ff  <= `TBFC_RST_CWCOND;
			modcond_ff <= `TBFC_RST_MODCOND;
		end else begin
			frame_ff <= nxt_frame;
			if (wr_hit(reg_idx, `TBFC_IDX_PINCTL, wr_acc, pstrb_i[0]))
				pinctl_ff <= pwdata_i[7:0];
			if (wr_hit(reg_idx, `TBFC_IDX_CWCOND, wr_acc, pstrb_i[0]))
				cwcond_ff <= pwdata_i[7:0];
			if (wr_hit(reg_idx, `TBFC_IDX_MODCOND, wr_acc, pstrb_i[0]))
				modcond_ff <= pwdata_i[7:0];
		end
	end

	// Read mux
	always @* begin
		case (reg_idx)
			`TBFC_IDX_FRAME:    rd_byte = frame_ff & `TBFC_FRAME_MASK;
			`TBFC_IDX_PINCTL:   rd_byte = pinctl_ff;
			`TBFC_IDX_CWCOND:   rd_byte = cwcond_ff;
			`TBFC_IDX_MODCOND:  rd_byte = modcond_ff;
			`TBFC_IDX_BITCOUNT: rd_byte = {4'h0, tx_bit_count_o};
			`TBFC_IDX_STATUS:   rd_byte = {6'h00, full_depth_o, tx_active_ff};
			default:            rd_byte = 8'h00;
		endcase
	end

	// APB answer: no wait state, ready in first access cycle, error on unmapped
	always @(posedge clk_i) begin
		if (srst_i) begin
			pready_o  <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o  <= 32'h00000000;
		end else begin
			pready_o  <= psel_i & ~penable_i;
			pslverr_o <= psel_i & ~penable_i & ~is_mapped(reg_idx);
			if (psel_i & ~penable_i)
				prdata_o <= {24'h000000, rd_byte};
		end
	end

	// Transmission activity for status; a new byte wins over a same-cycle done
	always @(posedge clk_i) begin
		if (srst_i)
			tx_active_ff <= 1'b0;
		else if (tx_byte_valid_i)
			tx_active_ff <= 1'b1;
		else if (tx_done_i)
			tx_active_ff <= 1'b0;
	end

	// Receive bit placement: first bit at alignment offset, later bits upward
	assign align_sum = {1'b0, frame_ff[`TBFC_ALIGN_HI:`TBFC_ALIGN_LO]} + rx_bit_index_i;
	always @(posedge clk_i) begin
		if (srst_i) begin
			rx_bit_pos_o  <= 3'h0;
			rx_byte_adv_o <= 1'b0;
		end else begin
			rx_bit_pos_o  <= align_sum[2:0];
			rx_byte_adv_o <= align_sum[3];
		end
	end

	// Final byte gating
	tbfc_bit_gate u_gate (
		.clk_i        (clk_i),
		.srst_i       (srst_i),
		.byte_valid_i (tx_byte_valid_i),
		.byte_last_i  (tx_byte_last_i),
		.last_bits_i  (frame_ff[`TBFC_LAST_HI:`TBFC_LAST_LO]),
		.bit_mask_o   (gate_mask),
		.bit_count_o  (gate_count)
	);

	// Carrier source
	tbfc_carrier_gen u_carrier (
		.clk_i     (clk_i),
		.srst_i    (srst_i),
		.carrier_o (carrier)
	);

	// Modulator input select; reserved code holds low
	always @* begin
		case (pinctl_ff[`TBFC_SRC_HI:`TBFC_SRC_LO])
			`TBFC_SRC_LOW:   mod_in = 1'b0;
			`TBFC_SRC_HIGH:  mod_in = 1'b1;
			`TBFC_SRC_CODER: mod_in = coder_data_i;
			default:         mod_in = 1'b0;
		endcase
	end

	// Antenna drive outputs and conductance selection
	always @(posedge clk_i) begin
		if (srst_i) begin
			mod_in_ff           <= 1'b0;
			antenna_drive_a_o   <= 1'b0;
			antenna_drive_b_o   <= 1'b0;
			drive_conductance_o <= 6'h00;
			full_depth_o        <= 1'b0;
			tx_bit_mask_o       <= 8'h00;
			tx_bit_count_o      <= 4'h0;
		end else begin
			mod_in_ff      <= mod_in;
			tx_bit_mask_o  <= gate_mask;
			tx_bit_count_o <= gate_count;
			// Modulation active high: full depth blanks carrier
			full_depth_o <= mod_in_ff & pinctl_ff[`TBFC_FORCE_BIT];
			if (!pinctl_ff[`TBFC_RF1_BIT])
				antenna_drive_a_o <= 1'b0;
			else
				antenna_drive_a_o <= carrier &
					~(mod_in_ff & pinctl_ff[`TBFC_FORCE_BIT]);
			if (!pinctl_ff[`TBFC_RF2_BIT])
				antenna_drive_b_o <= 1'b0;
			else if (pinctl_ff[`TBFC_CW_BIT])
				antenna_drive_b_o <= carrier ^ pinctl_ff[`TBFC_INV_BIT];
			else
				antenna_drive_b_o <= (carrier ^ pinctl_ff[`TBFC_INV_BIT]) &
					~(mod_in_ff & pinctl_ff[`TBFC_FORCE_BIT]);
			// Conductance: modulation value while modulating, else carrier value
			if (mod_in_ff)
				drive_conductance_o <= modcond_ff[`TBFC_COND_HI:`TBFC_COND_LO];
			else
				drive_conductance_o <= cwcond_ff[`TBFC_COND_HI:`TBFC_COND_LO];
		end
	end
endmodule
`default_nettype wire

// *** hdl/tbfc_map.vh ***
// Register offsets, field positions, reset values and timing constants for the
// transmit bit framing control block.
// Assumes a 32-bit APB master and byte addresses four times the register index.
// Functional notes
// - Receive alignment value gives bit position of the first received bit.
// - Transmitter sends only last-bits count bits of the final byte.
// - Last-bits zero sends whole byte; field self-clears after transmission ends.
// - Modulator input select: 00 low, 01 high, 10 coder, 11 reserved.
// - Full-depth keying bit forces 100 percent keying regardless of conductance.
// - Second-driver invert bit makes second output carry inverted carrier.
// - Second-driver steady-carrier bit gives continuous unmodulated second output.
// - Steady-carrier bit zero allows modulation on the second output.
// - Second RF enable on gives modulated carrier, off a constant level.
// - First RF enable on gives modulated carrier, off a constant level.
// - Six-bit carrier conductance field sets driver conductance.
// - Six-bit modulation conductance field sets conductance during modulation.
`ifndef TBFC_MAP_VH
`define TBFC_MAP_VH

// Register indices and byte addresses
`define TBFC_IDX_FRAME      8'h0F
`define TBFC_IDX_PINCTL     8'h11
`define TBFC_IDX_CWCOND     8'h12
`define TBFC_IDX_MODCOND    8'h13
`define TBFC_IDX_BITCOUNT   8'h20
`define TBFC_IDX_STATUS     8'h21
`define TBFC_ADDR_W         10
`define TBFC_IDX_LO         2

// Reset values
`define TBFC_RST_FRAME      8'h00
`define TBFC_RST_PINCTL     8'h48
`define TBFC_RST_CWCOND     8'h3F
`define TBFC_RST_MODCOND    8'h05

// Field positions
`define TBFC_ALIGN_HI       6
`define TBFC_ALIGN_LO       4
`define TBFC_LAST_HI        2
`define TBFC_LAST_LO        0
`define TBFC_FRAME_MASK     8'h77
`define TBFC_SRC_HI         6
`define TBFC_SRC_LO         5
`define TBFC_FORCE_BIT      4
`define TBFC_INV_BIT        3
`define TBFC_CW_BIT         2
`define TBFC_RF2_BIT        1
`define TBFC_RF1_BIT        0
`define TBFC_COND_HI        5
`define TBFC_COND_LO        0

// Modulator source codes
`define TBFC_SRC_LOW        2'h0
`define TBFC_SRC_HIGH       2'h1
`define TBFC_SRC_CODER      2'h2

// Carrier timing: 13.56 MHz carrier approximated by a phase accumulator
`define TBFC_CLK_HZ         100000000
`define TBFC_CARRIER_HZ     13560000
`define TBFC_PHASE_W        16
`define TBFC_PHASE_STEP     16'h22B6

`endif

// *** hdl/tbfc_carrier_gen.v ***
// Carrier generator: phase accumulator producing a square-wave carrier level.
// Assumes one clock; output is a registered level at roughly 13.56 MHz average.
`include "tbfc_map.vh"
`timescale 1ns/1ns
`default_nettype none
module tbfc_carrier_gen (
	input  wire clk_i,
	input  wire srst_i,
	output reg  carrier_o
);
	reg [`TBFC_PHASE_W-1:0] phase_ff;

	// Accumulate phase; top bit is the carrier level
	always @(posedge clk_i) begin
		if (srst_i) begin
			phase_ff  <= 16'h0000;
			carrier_o <= 1'b0;
		end else begin
			phase_ff  <= phase_ff + `TBFC_PHASE_STEP;
			carrier_o <= phase_ff[`TBFC_PHASE_W-1];
		end
	end
endmodule
`default_nettype wire

// *** hdl/tbfc_bit_gate.v ***
// Final byte bit gate: marks which bits of a transmitted byte go out.
// Assumes the framer asks for one byte at a time, last flag from the coder.
`include "tbfc_map.vh"
`timescale 1ns/1ns
`default_nettype none
module tbfc_bit_gate (
	input  wire       clk_i,
	input  wire       srst_i,
	input  wire       byte_valid_i,
	input  wire       byte_last_i,
	input  wire [2:0] last_bits_i,
	output reg  [7:0] bit_mask_o,
	output reg  [3:0] bit_count_o
);
	// Count of bits to send for a byte
	function [3:0] bits_for;
		input       last;
		input [2:0] lb;
		begin
			if (last && (lb != 3'h0))
				bits_for = {1'b0, lb};
			else
				bits_for = 4'h8;
		end
	endfunction

	// Mask of low bits sent, registered
	always @(posedge clk_i) begin
		if (srst_i) begin
			bit_mask_o  <= 8'h00;
			bit_count_o <= 4'h0;
		end else if (byte_valid_i) begin
			bit_count_o <= bits_for(byte_last_i, last_bits_i);
			bit_mask_o  <= 8'hFF >> (4'h8 - bits_for(byte_last_i, last_bits_i));
		end
	end
endmodule
`default_nettype wire

// *** verif/tbfc_chk.sv ***
// Checker of bus timing, final byte gating and receive alignment at the top ports.
// Assumes it is bound onto tbfc_top.
`timescale 1ns/1ns
`default_nettype none
module tbfc_chk (
	input wire logic        clk_i,
	input wire logic        srst_i,
	input wire logic        psel_i,
	input wire logic        penable_i,
	input wire logic        pready_o,
	input wire logic        pslverr_o,
	input wire logic [31:0] prdata_o,
	input wire logic        tx_byte_valid_i,
	input wire logic        tx_byte_last_i,
	input wire logic [7:0]  tx_bit_mask_o,
	input wire logic [3:0]  tx_bit_count_o,
	input wire logic [3:0]  rx_bit_index_i,
	input wire logic [2:0]  rx_bit_pos_o,
	input wire logic        rx_byte_adv_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (srst_i);
	// Byte requests to the gate
	sequence s_body; tx_byte_valid_i && !tx_byte_last_i; endsequence
	sequence s_tail; tx_byte_valid_i && tx_byte_last_i; endsequence
	property p_ack; psel_i && !penable_i |=> pready_o; endproperty
	a_ack: assert property (p_ack) else $error("no ready after setup");
	property p_pulse; pready_o |=> !pready_o; endproperty
	a_pulse: assert property (p_pulse) else $error("ready held");
	property p_idle; !psel_i |=> !pready_o; endproperty
	a_idle: assert property (p_idle) else $error("ready while idle");
	property p_err; pslverr_o |-> pready_o; endproperty
	a_err: assert property (p_err) else $error("error without ready");
	property p_hi; pready_o |-> prdata_o[31:8] == 24'h0; endproperty
	a_hi: assert property (p_hi) else $error("upper read data set");
	property p_body; s_body |-> ##2 tx_bit_count_o == 4'h8 && tx_bit_mask_o == 8'hFF; endproperty
	a_body: assert property (p_body) else $error("inner byte cut");
	property p_tail;
		s_tail |-> ##2 tx_bit_count_o inside {[4'h1:4'h8]} &&
			tx_bit_mask_o == 8'hFF >> (4'h8 - tx_bit_count_o);
	endproperty
	a_tail: assert property (p_tail) else $error("final mask wrong");
	property p_carry;
		!$past(srst_i) && $past(rx_bit_index_i) < 4'h8 |->
			rx_byte_adv_o == ({1'b0, rx_bit_pos_o} < $past(rx_bit_index_i));
	endproperty
	a_carry: assert property (p_carry) else $error("carry mismatch");
endmodule
`default_nettype wire

// *** verif/tbfc_field.sv ***
// Field probe: counts level changes seen on one antenna driver output.
// Assumes the driver output is a registered level on clk_i.
`timescale 1ns/1ns
`default_nettype none
module tbfc_field (
	input wire logic clk_i,
	input wire logic drv_i,
	output var int   edges_o
);
	logic last_ff;
	initial edges_o = 0;
	// Count every change of the driver level
	always @(posedge clk_i) begin
		last_ff <= drv_i;
		if (drv_i !== last_ff) edges_o <= edges_o + 1;
	end
endmodule
`default_nettype wire

// *** verif/tb.sv ***
// Testbench: APB register tests, gate and alignment checks, antenna activity.
// Assumes tbfc_top, tbfc_field and tbfc_chk are compiled.
`include "tbfc_map.vh"
`timescale 1ns/1ns
`default_nettype none
module tb;
	logic        clk, srst, psel, penable, pwrite, coder, bv, bl, done, pready, perr;
	logic        ta, tb2, radv, fd;
	logic [9:0]  paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0]  pstrb, ridx, cnt;
	logic [7:0]  mask, rd;
	logic [2:0]  rpos;
	logic [5:0]  cond;
	logic        er;
	int          err_count = 0, check_count = 0, cyc = 0, ea, eb;
	tbfc_top u_dut (.clk_i(clk), .srst_i(srst), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb),
		.prdata_o(prdata), .pready_o(pready), .pslverr_o(perr), .coder_data_i(coder),
		.tx_byte_valid_i(bv), .tx_byte_last_i(bl), .tx_done_i(done), .rx_bit_index_i(ridx),
		.rx_bit_pos_o(rpos), .rx_byte_adv_o(radv), .tx_bit_mask_o(mask),
		.tx_bit_count_o(cnt), .antenna_drive_a_o(ta), .antenna_drive_b_o(tb2),
		.drive_conductance_o(cond), .full_depth_o(fd));
	tbfc_field u_fa (.clk_i(clk), .drv_i(ta), .edges_o(ea));
	tbfc_field u_fb (.clk_i(clk), .drv_i(tb2), .edges_o(eb));
	initial begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	// Watchdog on the whole run
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 8000) begin
			err_count++;
			complete_run();
		end
	end
	task complete_run;
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			$display("BAD %s exp %h got %h", n, e, g);
			err_count++;
		end
	endtask
	// One APB transfer, entered and left just after an edge
	task bus(input logic w, input logic [7:0] i, input logic [7:0] d);
		psel <= 1; penable <= 0; pwrite <= w; paddr <= {i, 2'b00}; pwdata <= {24'h0, d};
		@(posedge clk) penable <= 1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata[7:0]; er = perr; psel <= 0; penable <= 0;
		@(posedge clk);
	endtask
	task rdc(input string n, input logic [7:0] i, input logic [7:0] e);
		bus(0, i, 8'h00);
		chk(n, e, rd);
	endtask
	task gate(input logic l, input logic [3:0] c);
		bv <= 1; bl <= l;
		@(posedge clk) bv <= 0;
		repeat (2) @(posedge clk);
		#1 chk("cnt", c, cnt);
		chk("mask", 8'hFF >> (8 - c), mask);
		@(posedge clk);
	endtask
	// Watch both drivers for a while after settling
	task act(input string n, input logic a, input logic b);
		int a0, b0;
		repeat (4) @(posedge clk);
		a0 = ea; b0 = eb;
		repeat (40) @(posedge clk);
		chk({n, "_a"}, a, ea != a0);
		chk({n, "_b"}, b, eb != b0);
	endtask
	// Count cycles where the two drivers break the expected phase relation
	task pair(input string n, input logic inv);
		int bad;
		bad = 0;
		repeat (4) @(posedge clk);
		repeat (20) begin
			@(posedge clk);
			if ((ta ^ tb2) !== inv) bad++;
		end
		chk(n, 0, bad);
	endtask
	initial begin
		srst = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; pstrb = 4'hF;
		coder = 0; bv = 0; bl = 0; done = 0; ridx = 0;
		repeat (8) @(posedge clk);
		srst <= 0;
		@(posedge clk);
		rdc("frame", `TBFC_IDX_FRAME, `TBFC_RST_FRAME);
		rdc("pinctl", `TBFC_IDX_PINCTL, `TBFC_RST_PINCTL);
		rdc("cw", `TBFC_IDX_CWCOND, `TBFC_RST_CWCOND);
		rdc("mod", `TBFC_IDX_MODCOND, `TBFC_RST_MODCOND);
		bus(1, `TBFC_IDX_FRAME, 8'hFF);
		rdc("frame_rsv", `TBFC_IDX_FRAME, 8'h77);
		bus(0, 8'h30, 8'h00);
		chk("unmapped_err", 1, er);
		chk("unmapped_rd", 0, rd);
		@(posedge clk) done <= 1;
		@(posedge clk) done <= 0;
		rdc("frame_clr", `TBFC_IDX_FRAME, 8'h70);
		$display("test registers done");
		for (int k = 0; k < 8; k++) begin
			bus(1, `TBFC_IDX_FRAME, 8'(k));
			gate(1, (k == 0) ? 4'h8 : 4'(k));
		end
		gate(0, 4'h8);
		rdc("bitcnt", `TBFC_IDX_BITCOUNT, 8'h08);
		bus(1, `TBFC_IDX_FRAME, 8'h70);
		for (int k = 0; k < 2; k++) begin
			ridx <= 4'(k);
			repeat (2) @(posedge clk);
			chk("pos", (k == 0) ? 7 : 0, rpos);
			chk("adv", k, radv);
		end
		$display("test framing done");
		bus(1, `TBFC_IDX_PINCTL, 8'h00);
		act("off", 0, 0);
		for (int s = 0; s < 4; s++) begin
			bus(1, `TBFC_IDX_PINCTL, {1'b0, 2'(s), 5'h13});
			act("src", s != 1, s != 1);
			chk("fd", s == 1, fd);
		end
		coder <= 1;
		bus(1, `TBFC_IDX_PINCTL, 8'h53);
		act("coder", 0, 0);
		chk("fd_on", 1, fd);
		rdc("status", `TBFC_IDX_STATUS, 8'h03);
		bus(1, `TBFC_IDX_PINCTL, 8'h37);
		act("steady", 0, 1);
		bus(1, `TBFC_IDX_PINCTL, 8'h3F);
		act("inv", 0, 1);
		bus(1, `TBFC_IDX_PINCTL, 8'h0F);
		pair("inv_pair", 1);
		bus(1, `TBFC_IDX_PINCTL, 8'h07);
		pair("same_pair", 0);
		$display("test antenna done");
		bus(1, `TBFC_IDX_CWCOND, 8'h2A);
		bus(1, `TBFC_IDX_MODCOND, 8'h15);
		pstrb <= 4'h0;
		bus(1, `TBFC_IDX_CWCOND, 8'h00);
		pstrb <= 4'hF;
		rdc("cw_strb", `TBFC_IDX_CWCOND, 8'h2A);
		bus(1, `TBFC_IDX_PINCTL, 8'h20);
		repeat (4) @(posedge clk);
		chk("cond_mod", 6'h15, cond);
		bus(1, `TBFC_IDX_PINCTL, 8'h00);
		repeat (4) @(posedge clk);
		chk("cond_cw", 6'h2A, cond);
		$display("test conductance done");
		complete_run();
	end
endmodule
bind tbfc_top tbfc_chk u_chk (.clk_i, .srst_i, .psel_i, .penable_i, .pready_o, .pslverr_o,
	.prdata_o, .tx_byte_valid_i, .tx_byte_last_i, .tx_bit_mask_o, .tx_bit_count_o,
	.rx_bit_index_i, .rx_bit_pos_o, .rx_byte_adv_o);
`default_nettype wire
